// [bench/bpf_pipe_model.sv]
// Fetch and decode pipeline model that feeds the prediction front end
`timescale 1ns/1ps
module bpf_pipe_model
   import bpf_pkg::*;
(
   input  wire logic   i_sys_clk,
   output bpf_fetch_t  o_fetch,
   output logic        o_next_undef,
   output logic        o_spin_hint,
   output bpf_resolve_t o_resolve
);
   initial begin
      o_fetch      = '0;
      o_next_undef = 1'b0;
      o_spin_hint  = 1'b0;
      o_resolve    = '0;
   end

   // ************************************************
   // Requests launched on the falling edge
   // ************************************************
   // Idle fields except kind flip so a stale value never looks valid
   task automatic fetch_br(input bpf_kind_t k, input logic [31:0] pc, input logic [31:0] tg,
                           input logic undef);
      @(negedge i_sys_clk);
      o_fetch      = '{valid: 1'b1, kind: k, pc: pc, target: tg};
      o_next_undef = undef;
      @(negedge i_sys_clk);
      o_fetch.valid  = 1'b0;
      o_fetch.pc     = ~pc;
      o_fetch.target = ~tg;
      o_next_undef   = ~undef;
   endtask

   task automatic resolve_br(input bpf_kind_t k, input logic tk, input logic [31:0] pc,
                             input logic [31:0] tg);
      @(negedge i_sys_clk);
      o_resolve = '{valid: 1'b1, kind: k, taken: tk, pc: pc, target: tg};
      @(negedge i_sys_clk);
      o_resolve.valid  = 1'b0;
      o_resolve.taken  = ~tk;
      o_resolve.pc     = ~pc;
      o_resolve.target = ~tg;
   endtask

   task automatic spin;
      @(negedge i_sys_clk);
      o_spin_hint = 1'b1;
      @(negedge i_sys_clk);
      o_spin_hint = 1'b0;
   endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the branch prediction front end
`timescale 1ns/1ps
module tb_top;
   import bpf_pkg::*;
   logic         i_sys_clk;
   logic         i_srst;
   logic         i_dyn_only;
   bpf_fetch_t   fetch;
   logic         next_undef;
   logic         spin_hint;
   bpf_resolve_t resolve;
   bpf_pred_t    o_pred;
   logic         o_from_btb;
   logic         o_decode_stop;
   logic         o_spin_mode;
   int           err_count;
   int           cmp_count;
   int           cycles;
   logic [31:0]  a;

   bpf_pipe_model PM (.i_sys_clk(i_sys_clk), .o_fetch(fetch), .o_next_undef(next_undef),
                      .o_spin_hint(spin_hint), .o_resolve(resolve));
   bpf_front_end DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_dyn_only(i_dyn_only),
                      .i_fetch(fetch), .i_next_undef(next_undef), .i_spin_hint(spin_hint),
                      .i_resolve(resolve), .o_pred(o_pred), .o_from_btb(o_from_btb),
                      .o_decode_stop(o_decode_stop), .o_spin_mode(o_spin_mode));

   initial begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end

   // Generous ceiling, the tests need well under a thousand cycles
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count = err_count + 1;
         results;
      end
   end

   // ************************************************
   // Shared checks
   // ************************************************
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic fp(input bpf_kind_t k, input logic [31:0] pc, input logic [31:0] tg,
                     input logic undef, input logic et, input logic [31:0] etg,
                     input logic eb);
      PM.fetch_br(k, pc, tg, undef);
      chk({30'h0, o_pred}, {30'h0, 1'b1, et, etg});
      chk({63'h0, o_from_btb}, {63'h0, eb});
   endtask

   task automatic do_reset(input int n);
      @(negedge i_sys_clk);
      i_srst = 1'b1;
      repeat (n) @(negedge i_sys_clk);
      i_srst = 1'b0;
   endtask

   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_static;
      fp(BPF_BR_UNCOND, 32'h0000_0100, 32'h0000_0400, 1'b0, 1'b1, 32'h0000_0400, 1'b0);
      fp(BPF_BR_COND, 32'h0000_0104, 32'h0000_0040, 1'b0, 1'b1, 32'h0000_0040, 1'b0);
      fp(BPF_BR_COND, 32'h0000_0108, 32'h0000_0800, 1'b0, 1'b0, 32'h0000_010C, 1'b0);
      fp(BPF_BR_INDIRECT, 32'h0000_010C, 32'h0000_0900, 1'b0, 1'b0, 32'h0000_0110, 1'b0);
      fp(BPF_BR_IND_CALL, 32'h0000_0110, 32'h0000_0A00, 1'b0, 1'b0, 32'h0000_0114, 1'b0);
      // Forward branch once taken now comes from the buffer
      PM.resolve_br(BPF_BR_COND, 1'b1, 32'h0000_0108, 32'h0000_0800);
      fp(BPF_BR_COND, 32'h0000_0108, 32'h0000_0800, 1'b0, 1'b1, 32'h0000_0800, 1'b1);
      PM.resolve_br(BPF_BR_COND, 1'b0, 32'h0000_0114, 32'h0000_0A00);
      fp(BPF_BR_COND, 32'h0000_0114, 32'h0000_0A00, 1'b0, 1'b0, 32'h0000_0118, 1'b0);
      $display("static test done");
   endtask

   task automatic t_dyn;
      @(negedge i_sys_clk);
      i_dyn_only = 1'b1;
      // Backward miss is not taken here, unlike the static algorithm
      fp(BPF_BR_COND, 32'h0000_0204, 32'h0000_0040, 1'b0, 1'b0, 32'h0000_0208, 1'b0);
      PM.resolve_br(BPF_BR_COND, 1'b1, 32'h0000_0204, 32'h0000_0040);
      fp(BPF_BR_COND, 32'h0000_0204, 32'h0000_0040, 1'b0, 1'b1, 32'h0000_0040, 1'b1);
      fp(BPF_BR_UNCOND, 32'h0000_0208, 32'h0000_0600, 1'b0, 1'b1, 32'h0000_0600, 1'b0);
      @(negedge i_sys_clk);
      i_dyn_only = 1'b0;
      $display("dynamic test done");
   endtask

   task automatic t_indirect;
      PM.resolve_br(BPF_BR_INDIRECT, 1'b1, 32'h0000_0300, 32'h0000_5000);
      fp(BPF_BR_INDIRECT, 32'h0000_0300, 32'h0000_0000, 1'b0, 1'b1, 32'h0000_5000, 1'b1);
      PM.resolve_br(BPF_BR_INDIRECT, 1'b1, 32'h0000_0300, 32'h0000_6000);
      fp(BPF_BR_INDIRECT, 32'h0000_0300, 32'h0000_0000, 1'b0, 1'b1, 32'h0000_6000, 1'b1);
      fp(BPF_BR_INDIRECT, 32'h0000_0300, 32'h0000_0000, 1'b0, 1'b1, 32'h0000_6000, 1'b1);
      $display("indirect test done");
   endtask

   task automatic t_ras;
      // Seventeen calls, the oldest return address is lost
      for (int i = 0; i < 17; i++) begin
         a = 32'h0000_1000 + 32'(i) * 32'h0000_0010;
         fp(BPF_BR_CALL, a, 32'h0000_8000, 1'b0, 1'b1, 32'h0000_8000, 1'b0);
      end
      for (int j = 0; j < 16; j++) begin
         a = 32'h0000_1004 + 32'(16 - j) * 32'h0000_0010;
         fp(BPF_BR_RETURN, 32'h0000_8040, 32'h0000_0000, 1'b0, 1'b1, a, 1'b0);
      end
      $display("return stack test done");
   endtask

   task automatic t_stop_spin;
      fp(BPF_BR_INDIRECT, 32'h0000_0700, 32'h0000_0000, 1'b1, 1'b0, 32'h0000_0704, 1'b0);
      chk({63'h0, o_decode_stop}, 64'h1);
      fp(BPF_BR_INDIRECT, 32'h0000_0740, 32'h0000_0000, 1'b0, 1'b0, 32'h0000_0744, 1'b0);
      chk({63'h0, o_decode_stop}, 64'h0);
      PM.spin;
      chk({63'h0, o_spin_mode}, 64'h1);
      fp(BPF_BR_COND, 32'h0000_0780, 32'h0000_0080, 1'b0, 1'b1, 32'h0000_0080, 1'b0);
      fp(BPF_BR_NONE, 32'h0000_07C0, 32'h0000_0040, 1'b0, 1'b0, 32'h0000_07C4, 1'b0);
      repeat (10) @(negedge i_sys_clk);
      chk({63'h0, o_spin_mode}, 64'h1);
      repeat (8) @(negedge i_sys_clk);
      chk({63'h0, o_spin_mode}, 64'h0);
      $display("stop and spin test done");
   endtask

   task automatic t_reset;
      PM.resolve_br(BPF_BR_COND, 1'b1, 32'h0000_0108, 32'h0000_0800);
      fp(BPF_BR_CALL, 32'h0000_0900, 32'h0000_8000, 1'b0, 1'b1, 32'h0000_8000, 1'b0);
      do_reset(2);
      chk({30'h0, o_pred}, 64'h0);
      fp(BPF_BR_COND, 32'h0000_0108, 32'h0000_0800, 1'b0, 1'b0, 32'h0000_010C, 1'b0);
      fp(BPF_BR_RETURN, 32'h0000_8040, 32'h0000_0000, 1'b0, 1'b0, 32'h0000_8044, 1'b0);
      $display("reset test done");
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      err_count  = 0;
      cmp_count  = 0;
      cycles     = 0;
      i_srst     = 1'b1;
      i_dyn_only = 1'b0;
      repeat (20) @(negedge i_sys_clk);
      i_srst = 1'b0;
      t_static;
      t_dyn;
      t_indirect;
      t_ras;
      t_stop_spin;
      t_reset;
      results;
   end
endmodule

// [include/bpf_pkg.sv]
// Package of types and constants for the branch prediction front end
// Notes on behaviour
// - Branches missing from the target buffer use the static algorithm, except conditional branches in dynamic-only mode.
// - Static: unconditional branches predicted taken.
// - Static: backward conditional branches predicted taken.
// - Static: forward conditional branches predicted not taken, fall through.
// - Static: indirect branches predicted not taken, fall through.
// - Dynamic-only mode predicts every conditional branch dynamically, even first time.
// - A sixteen-entry return stack, pushed by calls, predicts return targets.
// - Indirect branches or calls without prediction default to fall-through target.
// - A held indirect prediction replaces the fall-through default.
// - Indirect target predicted is the one taken on previous execution.
// - Each buffer entry stores one taken target; newer taken target replaces it.
// - Never-taken conditional branches get no buffer entry.
// - Indirect branch followed by undefined opcode stops fall-through decode.
// - Spin-wait hint executes as a no-operation.
// - Spin-wait hint lowers memory order violation flagging on loop exit.
package bpf_pkg;

   localparam int BPF_ADDR_W    = 32;
   localparam int BPF_BTB_DEPTH = 16;
   localparam int BPF_RAS_DEPTH = 16;
   localparam int BPF_SPIN_HOLD = 16;
   localparam logic [BPF_ADDR_W-1:0] BPF_INSN_STEP = 32'h0000_0004;

   typedef enum logic [2:0] {
      BPF_BR_NONE,
      BPF_BR_UNCOND,
      BPF_BR_COND,
      BPF_BR_INDIRECT,
      BPF_BR_CALL,
      BPF_BR_IND_CALL,
      BPF_BR_RETURN
   } bpf_kind_t;

   typedef struct packed {
      logic                  valid;
      bpf_kind_t             kind;
      logic [BPF_ADDR_W-1:0] pc;
      logic [BPF_ADDR_W-1:0] target;
   } bpf_fetch_t;

   typedef struct packed {
      logic                  valid;
      logic                  taken;
      logic [BPF_ADDR_W-1:0] target;
   } bpf_pred_t;

   typedef struct packed {
      logic                  valid;
      bpf_kind_t             kind;
      logic                  taken;
      logic [BPF_ADDR_W-1:0] pc;
      logic [BPF_ADDR_W-1:0] target;
   } bpf_resolve_t;

endpackage

// [logic/bpf_front_end.sv]
// Branch prediction front end: target buffer, static and dynamic direction
`timescale 1ns/1ps
module bpf_front_end
   import bpf_pkg::*;
#(
   parameter int BTB_DEPTH = BPF_BTB_DEPTH,
   parameter int RAS_DEPTH = BPF_RAS_DEPTH
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_srst,
   input  wire logic         i_dyn_only,
   input  wire bpf_fetch_t   i_fetch,
   input  wire logic         i_next_undef,
   input  wire logic         i_spin_hint,
   input  wire bpf_resolve_t i_resolve,
   output bpf_pred_t         o_pred,
   output logic              o_from_btb,
   output logic              o_decode_stop,
   output logic              o_spin_mode
);
   localparam int IW = $clog2(BTB_DEPTH);

   // ****************************************
   // Target buffer storage
   // ****************************************
   logic                  vld_reg [BTB_DEPTH];
   logic [BPF_ADDR_W-1:0] tag_reg [BTB_DEPTH];
   logic [BPF_ADDR_W-1:0] tgt_reg [BTB_DEPTH];
   logic [1:0]            ctr_reg [BTB_DEPTH];

   logic [IW-1:0] f_idx;
   logic [IW-1:0] r_idx;
   logic          btb_hit;
   logic          r_hit;
   logic          alloc;

   assign f_idx   = i_fetch.pc[IW+1:2];
   assign r_idx   = i_resolve.pc[IW+1:2];
   assign btb_hit = vld_reg[f_idx] && (tag_reg[f_idx] == i_fetch.pc);
   assign r_hit   = vld_reg[r_idx] && (tag_reg[r_idx] == i_resolve.pc);
   assign alloc   = i_resolve.valid && i_resolve.taken && (i_resolve.kind != BPF_BR_RETURN)
                    && (i_resolve.kind != BPF_BR_NONE);

   genvar g;
   generate
      for (g = 0; g < BTB_DEPTH; g++) begin : g_btb
         always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
               vld_reg[g] <= 1'b0;
            end else if (alloc && r_idx == IW'(g)) begin
               vld_reg[g] <= 1'b1;
            end
         end
         always_ff @(posedge i_sys_clk) begin
            if (alloc && r_idx == IW'(g)) begin
               tag_reg[g] <= i_resolve.pc;
               tgt_reg[g] <= i_resolve.target;
            end
         end
         // Two-bit saturating direction counter
         always_ff @(posedge i_sys_clk) begin
            if (i_srst) begin
               ctr_reg[g] <= 2'h2;
            end else if (i_resolve.valid && r_idx == IW'(g)) begin
               if (alloc && !r_hit) begin
                  ctr_reg[g] <= 2'h3;
               end else if (r_hit && i_resolve.taken && ctr_reg[g] != 2'h3) begin
                  ctr_reg[g] <= ctr_reg[g] + 2'h1;
               end else if (r_hit && !i_resolve.taken && ctr_reg[g] != 2'h0) begin
                  ctr_reg[g] <= ctr_reg[g] - 2'h1;
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Return stack
   // ****************************************
   logic                  is_call;
   logic                  is_ret;
   logic                  ras_hit;
   logic [BPF_ADDR_W-1:0] ras_top;
   logic [BPF_ADDR_W-1:0] fall_thru;

   assign fall_thru = i_fetch.pc + BPF_INSN_STEP;
   assign is_call   = i_fetch.valid && (i_fetch.kind == BPF_BR_CALL ||
                                        i_fetch.kind == BPF_BR_IND_CALL);
   assign is_ret    = i_fetch.valid && (i_fetch.kind == BPF_BR_RETURN);

   // push on call, pop on return
   bpf_ret_stack #(
      .DEPTH (RAS_DEPTH)
   ) u_ras (
      .i_sys_clk   (i_sys_clk),
      .i_srst      (i_srst),
      .i_push      (is_call),
      .i_pop       (is_ret),
      .i_push_addr (fall_thru),
      .o_hit       (ras_hit),
      .o_top       (ras_top)
   );

   // ****************************************
   // Prediction
   // ****************************************
   logic                  p_taken;
   logic [BPF_ADDR_W-1:0] p_target;
   logic                  backward;

   assign backward = (i_fetch.target < i_fetch.pc);

   always_comb begin
      p_taken  = 1'b0;
      p_target = fall_thru;
      case (i_fetch.kind)
         BPF_BR_UNCOND, BPF_BR_CALL: begin
            p_taken  = 1'b1;
            p_target = i_fetch.target;
         end
         BPF_BR_COND: begin
            if (btb_hit || i_dyn_only) begin
               p_taken = btb_hit ? ctr_reg[f_idx][1] : 1'b0;
            end else begin
               p_taken = backward;
            end
            p_target = p_taken ? i_fetch.target : fall_thru;
         end
         BPF_BR_INDIRECT, BPF_BR_IND_CALL: begin
            if (btb_hit) begin
               p_taken  = 1'b1;
               p_target = tgt_reg[f_idx];
            end else begin
               p_taken  = 1'b0;
               p_target = fall_thru;
            end
         end
         BPF_BR_RETURN: begin
            p_taken  = ras_hit;
            p_target = ras_hit ? ras_top : fall_thru;
         end
         default: begin
            // spin hint and others flow as no-op
            p_taken  = 1'b0;
            p_target = fall_thru;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_pred     <= '0;
         o_from_btb <= 1'b0;
      end else begin
         o_pred.valid  <= i_fetch.valid;
         o_pred.taken  <= p_taken;
         o_pred.target <= p_target;
         o_from_btb    <= i_fetch.valid && btb_hit;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_decode_stop <= 1'b0;
      end else begin
         o_decode_stop <= i_fetch.valid && i_next_undef && !p_taken &&
                          (i_fetch.kind == BPF_BR_INDIRECT ||
                           i_fetch.kind == BPF_BR_IND_CALL);
      end
   end

   // ****************************************
   // Spin-wait handling
   // ****************************************
   logic [$clog2(BPF_SPIN_HOLD+1)-1:0] spin_cnt_reg;

   // hold relaxed ordering past loop exit
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         spin_cnt_reg <= '0;
      end else if (i_spin_hint) begin
         spin_cnt_reg <= BPF_SPIN_HOLD[$clog2(BPF_SPIN_HOLD+1)-1:0];
      end else if (spin_cnt_reg != '0) begin
         spin_cnt_reg <= spin_cnt_reg - 1'b1;
      end
   end
   assign o_spin_mode = (spin_cnt_reg != '0);

   // ****************************************
   // Checks
   // ****************************************
   property p_uncond;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_fetch.valid && i_fetch.kind == BPF_BR_UNCOND) |=> (o_pred.taken && o_pred.valid);
   endproperty
   a_uncond: assert property (p_uncond) else $error("uncond not taken");

   property p_back;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_fetch.valid && i_fetch.kind == BPF_BR_COND && !btb_hit && !i_dyn_only && backward)
      |=> o_pred.taken;
   endproperty
   a_back: assert property (p_back) else $error("backward not taken");

   property p_fwd;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_fetch.valid && i_fetch.kind == BPF_BR_COND && !btb_hit && !backward)
      |=> (!o_pred.taken && o_pred.target == $past(fall_thru));
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward taken");

   property p_ind_def;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_fetch.valid && i_fetch.kind == BPF_BR_INDIRECT && !btb_hit)
      |=> (!o_pred.taken && o_pred.target == $past(i_fetch.pc) + BPF_INSN_STEP);
   endproperty
   a_ind_def: assert property (p_ind_def) else $error("indirect default wrong");

   property p_ind_hit;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_fetch.valid && i_fetch.kind == BPF_BR_INDIRECT && btb_hit)
      |=> (o_pred.taken && o_from_btb);
   endproperty
   a_ind_hit: assert property (p_ind_hit) else $error("held target ignored");

   sequence s_ind_learn;
      (i_resolve.valid && i_resolve.taken && i_resolve.kind == BPF_BR_INDIRECT)
      ##1 !i_resolve.valid;
   endsequence

   sequence s_ind_refetch;
      i_fetch.valid && i_fetch.kind == BPF_BR_INDIRECT && i_fetch.pc == $past(i_resolve.pc, 2);
   endsequence

   property p_ind_prev;
      @(posedge i_sys_clk) disable iff (i_srst)
      s_ind_learn ##1 s_ind_refetch |=> (o_pred.taken && o_pred.target == $past(i_resolve.target, 3));
   endproperty
   a_ind_prev: assert property (p_ind_prev) else $error("previous target not used");

   property p_no_alloc;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_resolve.valid && !i_resolve.taken && !r_hit) |=> !(vld_reg[$past(r_idx)] &&
         tag_reg[$past(r_idx)] == $past(i_resolve.pc));
   endproperty
   a_no_alloc: assert property (p_no_alloc) else $error("never-taken allocated");

   property p_stop;
      @(posedge i_sys_clk) disable iff (i_srst)
      (i_fetch.valid && i_fetch.kind == BPF_BR_INDIRECT && !btb_hit && i_next_undef)
      |=> o_decode_stop;
   endproperty
   a_stop: assert property (p_stop) else $error("decode not stopped");

   property p_spin;
      @(posedge i_sys_clk) disable iff (i_srst)
      i_spin_hint |=> o_spin_mode [*8];
   endproperty
   a_spin: assert property (p_spin) else $error("spin window short");
endmodule

// [logic/bpf_ret_stack.sv]
// Circular return address stack
`timescale 1ns/1ps
module bpf_ret_stack
   import bpf_pkg::*;
#(
   parameter int DEPTH = BPF_RAS_DEPTH
) (
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_srst,
   input  wire logic                  i_push,
   input  wire logic                  i_pop,
   input  wire logic [BPF_ADDR_W-1:0] i_push_addr,
   output logic                       o_hit,
   output logic [BPF_ADDR_W-1:0]      o_top
);
   localparam int PW = $clog2(DEPTH);

   logic [BPF_ADDR_W-1:0] mem_reg [DEPTH];
   logic [PW-1:0]         top_reg;
   logic [PW:0]           cnt_reg;

   assign o_hit = (cnt_reg != '0);
   assign o_top = mem_reg[top_reg];

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         top_reg <= '0;
      end else if (i_push) begin
         top_reg <= top_reg + 1'b1;
      end else if (i_pop && o_hit) begin
         top_reg <= top_reg - 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_push) begin
         mem_reg[top_reg + 1'b1] <= i_push_addr;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         cnt_reg <= '0;
      end else if (i_push) begin
         if (cnt_reg != DEPTH[PW:0]) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end else if (i_pop && o_hit) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   property p_push_pop;
      @(posedge i_sys_clk) disable iff (i_srst)
      i_push |=> (o_hit && o_top == $past(i_push_addr));
   endproperty
   a_push_pop: assert property (p_push_pop) else $error("push not on top");

   property p_reset_empty;
      @(posedge i_sys_clk) i_srst |=> !o_hit;
   endproperty
   a_reset_empty: assert property (p_reset_empty) else $error("stack not empty");
endmodule
